// ===== hw/fsp_core.sv
/*
  Status, configuration and array protection logic of a serial flash.
  Assumes a host on the serial link (own clock, chip select active low) and
  a memory engine outside that acts on memOpGo; rst_n stands for a power cycle.
*/
// What this block does
// - guard 0 and unlocked: pin ignored, latch suffices
// - guard 1, pin low: status writes locked
// - guard 1, pin high: writes need latch
// - lock-down refuses writes until power cycle
// - prefix AAh 55h makes lock permanent
// - pin matters only outside quad mode
// - suspend sets paused flag, resume clears
// - security locks set once, cleared only by power cycle
// - quad bit swaps pause pin for lines
// - current address width shows 3/4 bytes
// - powerup width used at reset, write-enabled
// - powerup width picks starting address mode
// - scheme bit picks map or block locks
// - block locks all set at every reset
// - two-bit drive strength, default 25 percent
// - reserved bits read zero, writes ignored
// - value n guards 2^(n-1) top/bottom blocks
// - zero guards none, high codes guard all
// - erase/program touching guarded area ignored
// - latch set by enable, cleared by writes
// - complement bit inverts guarded region
module fsp_core (
  input wire logic clock, // register clock
  input wire logic rst_n, // power cycle, async
  input wire logic spiClk, // serial link clock
  input wire logic spiCsN, // chip select
  input wire logic spiMosi, // serial data in
  output logic spiMiso, // serial data out
  output logic spiMisoOeN, // data out enable
  input wire logic wpPinN, // write protect pin
  output logic memOpGo, // accepted array operation
  output fsp_pkg::fsp_memop_t memOp, // operation and address
  output logic [2:0] securityLocks, // security register locks
  output logic quadAllow, // quad lines enabled
  output logic pauseEnable, // pause pin active
  output logic [1:0] driveStrength, // read drive code
  output logic addr4Byte, // 4-byte address mode
  output logic guardScheme // block locks in force
);
  // link side
  logic [2:0] bitCnt_r;
  logic [7:0] shiftIn_r;
  logic firstDone_r;
  logic [1:0] readSel_r;
  logic [7:0] byteHold_r;
  logic byteTog_r;
  logic partial_r;
  logic misoBit_r;
  logic [23:0] pubStatus_r;
  wire [7:0] shiftNxt = {shiftIn_r[6:0], spiMosi};
  wire byteDone = bitCnt_r == 3'h7;
  wire [1:0] readPick = (shiftNxt == fsp_pkg::OP_RDSR1) ? 2'h1 :
                        (shiftNxt == fsp_pkg::OP_RDSR2) ? 2'h2 :
                        (shiftNxt == fsp_pkg::OP_RDSR3) ? 2'h3 : 2'h0;
  wire [7:0] readByte = (readSel_r == 2'h1) ? pubStatus_r[7:0] :
                        (readSel_r == 2'h2) ? pubStatus_r[15:8] : pubStatus_r[23:16];

  // frame state dies with chip select
  always_ff @(posedge spiClk or posedge spiCsN or negedge rst_n)
  begin
    if (!rst_n || spiCsN)
    begin
      bitCnt_r <= 3'h0;
      shiftIn_r <= 8'h00;
      firstDone_r <= 1'b0;
      readSel_r <= 2'h0;
    end
    else
    begin
      bitCnt_r <= bitCnt_r + 3'h1;
      shiftIn_r <= shiftNxt;
      if (byteDone && !firstDone_r)
      begin
        firstDone_r <= 1'b1;
        readSel_r <= readPick;
      end
    end
  end

  // byte hand-off survives the frame so the register side can still fetch it
  always_ff @(posedge spiClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byteHold_r <= 8'h00;
      byteTog_r <= 1'b0;
      partial_r <= 1'b0;
    end
    else
    begin
      partial_r <= !byteDone;
      if (byteDone)
      begin
        byteHold_r <= shiftNxt;
        byteTog_r <= !byteTog_r;
      end
    end
  end

  // snapshot is frozen while a frame is open, so it is quasi-static here
  always_ff @(negedge spiClk or negedge rst_n)
  begin
    if (!rst_n)
      misoBit_r <= 1'b0;
    else
      misoBit_r <= readByte[3'h7 - bitCnt_r];
  end

  assign spiMiso = misoBit_r;
  assign spiMisoOeN = spiCsN || (readSel_r == 2'h0);

  // register side
  logic [1:0] csSync_r;
  logic [1:0] togSync_r;
  logic [1:0] wpSync_r;
  logic togSeen_r;
  logic csPrev_r;
  logic frameEndD_r;
  logic [7:0] cmd_r;
  logic [2:0] byteCnt_r;
  logic [31:0] addr_r;
  logic [7:0] data1_r;
  fsp_pkg::fsp_sr1_t sr1_r, sr1_nxt;
  fsp_pkg::fsp_sr2_t sr2_r, sr2_nxt;
  fsp_pkg::fsp_sr3_t sr3_r, sr3_nxt;
  logic otpLock_r;
  logic [1:0] armStage_r;
  logic rstArm_r;
  logic initPend_r;
  logic [511:0] lockBits_r, lockBits_nxt;
  logic memOpGo_r;
  fsp_pkg::fsp_memop_t memOp_r;

  wire csHigh = csSync_r[1];
  wire frameEnd = csHigh && !csPrev_r;
  wire byteEvt = togSync_r[1] ^ togSeen_r;
  wire [2:0] addrLen = sr3_r.currentAddressWidth ? fsp_pkg::ADDR4_BYTES : fsp_pkg::ADDR3_BYTES;
  wire exec = frameEndD_r && !partial_r && (byteCnt_r != 3'h0);
  wire oneByte = exec && (byteCnt_r == 3'h1);
  wire withData = exec && (byteCnt_r >= 3'h2);
  wire addrEnough = exec && (byteCnt_r > addrLen);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      csSync_r <= fsp_pkg::SYNC_IDLE_HIGH;
      togSync_r <= 2'h0;
      wpSync_r <= fsp_pkg::SYNC_IDLE_HIGH;
      togSeen_r <= 1'b0;
      csPrev_r <= 1'b1;
      frameEndD_r <= 1'b0;
    end
    else
    begin
      csSync_r <= {csSync_r[0], spiCsN};
      togSync_r <= {togSync_r[0], byteTog_r};
      wpSync_r <= {wpSync_r[0], wpPinN};
      togSeen_r <= togSync_r[1];
      csPrev_r <= csHigh;
      frameEndD_r <= frameEnd;
    end
  end

  // byte collector; frame end is delayed one cycle so a late last byte lands first
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_r <= 8'h00;
      byteCnt_r <= 3'h0;
      addr_r <= 32'h0000_0000;
      data1_r <= 8'h00;
    end
    else if (frameEndD_r)
    begin
      byteCnt_r <= 3'h0;
      addr_r <= 32'h0000_0000;
    end
    else if (byteEvt)
    begin
      if (byteCnt_r != 3'h7)
        byteCnt_r <= byteCnt_r + 3'h1;
      if (byteCnt_r == 3'h0)
        cmd_r <= byteHold_r;
      if (byteCnt_r == 3'h1)
        data1_r <= byteHold_r;
      if (byteCnt_r != 3'h0 && byteCnt_r <= addrLen)
        addr_r <= {addr_r[23:0], byteHold_r};
    end
  end

  // instruction decode
  wire doWren = oneByte && cmd_r == fsp_pkg::OP_WREN;
  wire doWrdi = oneByte && cmd_r == fsp_pkg::OP_WRDI;
  wire wrSr1 = withData && cmd_r == fsp_pkg::OP_WRSR1;
  wire wrSr2 = withData && cmd_r == fsp_pkg::OP_WRSR2;
  wire wrSr3 = withData && cmd_r == fsp_pkg::OP_WRSR3;
  wire anyWrSr = wrSr1 || wrSr2 || wrSr3;
  wire isSuspend = oneByte && cmd_r == fsp_pkg::OP_SUSPEND;
  wire isResume = oneByte && cmd_r == fsp_pkg::OP_RESUME;
  wire isEnter4 = oneByte && cmd_r == fsp_pkg::OP_ENTER4;
  wire isExit4 = oneByte && cmd_r == fsp_pkg::OP_EXIT4;
  wire isPrefixA = oneByte && cmd_r == fsp_pkg::OP_PREFIX_A;
  wire isPrefixB = oneByte && cmd_r == fsp_pkg::OP_PREFIX_B && armStage_r == 2'h1;
  wire isRstEn = oneByte && cmd_r == fsp_pkg::OP_RESET_EN;
  wire softRst = oneByte && cmd_r == fsp_pkg::OP_RESET && rstArm_r;
  wire isArrayOp = cmd_r == fsp_pkg::OP_PROGRAM || cmd_r == fsp_pkg::OP_SECT_ERASE ||
                   cmd_r == fsp_pkg::OP_BLK_ERASE;
  wire isSecOp = cmd_r == fsp_pkg::OP_SEC_ERASE || cmd_r == fsp_pkg::OP_SEC_PROGRAM;
  wire memReq = addrEnough && isArrayOp;
  wire ceReq = oneByte && cmd_r == fsp_pkg::OP_CHIP_ERASE;
  wire secReq = addrEnough && isSecOp;
  wire lockReq = addrEnough && (cmd_r == fsp_pkg::OP_BLK_LOCK || cmd_r == fsp_pkg::OP_BLK_UNLOCK);
  wire latch = sr1_r.writeAllowLatch;

  wire hwLocked = sr1_r.statusGuard && !sr2_r.quadAllow && !wpSync_r[1];
  wire srWriteOk = latch && !sr2_r.statusLockDown && !otpLock_r && !hwLocked;

  // array protection lookup for the addressed block
  wire [8:0] blkAddr = addr_r[fsp_pkg::BLOCK_LSB +: 9];
  wire [3:0] bp = sr1_r.blockGuard;
  wire invert = sr2_r.complementGuard;
  wire bpAll = bp[3] && (bp[1] || bp[2]);
  wire [9:0] protCnt = 10'h001 << (bp - 4'h1);
  wire [9:0] blkWide = {1'b0, blkAddr};
  wire inTop = blkWide >= (fsp_pkg::BLOCK_COUNT - protCnt);
  wire inBottom = blkWide < protCnt;
  // power-of-two region at top or bottom
  wire baseProt = bpAll || ((bp != 4'h0) && (sr1_r.topBottomSelect ? inBottom : inTop));
  wire blkProt = sr3_r.guardSchemeSelect ? lockBits_r[blkAddr] : (baseProt ^ invert);
  wire anyProt = sr3_r.guardSchemeSelect ? (|lockBits_r) : (invert ? !bpAll : (bp != 4'h0));
  wire [1:0] secIdx = addr_r[fsp_pkg::SEC_IDX_LSB +: 2];
  wire secProt = (secIdx == 2'h0) || sr2_r.securityLock[2'(secIdx - 2'h1)];
  wire memGoNxt = latch && ((memReq && !blkProt) || (ceReq && !anyProt) || (secReq && !secProt));
  wire fsp_pkg::fsp_memop_kind_t kindNxt =
    ceReq ? fsp_pkg::MOP_CHIP_ERASE :
    cmd_r == fsp_pkg::OP_PROGRAM ? fsp_pkg::MOP_PAGE_PROGRAM :
    cmd_r == fsp_pkg::OP_SECT_ERASE ? fsp_pkg::MOP_SECTOR_ERASE :
    cmd_r == fsp_pkg::OP_BLK_ERASE ? fsp_pkg::MOP_BLOCK_ERASE :
    cmd_r == fsp_pkg::OP_SEC_ERASE ? fsp_pkg::MOP_SEC_ERASE : fsp_pkg::MOP_SEC_PROGRAM;
  wire fsp_pkg::fsp_sr1_t wr1 = fsp_pkg::fsp_sr1_t'(data1_r);
  wire fsp_pkg::fsp_sr2_t wr2 = fsp_pkg::fsp_sr2_t'(data1_r);
  wire fsp_pkg::fsp_sr3_t wr3 = fsp_pkg::fsp_sr3_t'(data1_r);
  wire clrWel = doWrdi || memReq || ceReq || secReq || lockReq || anyWrSr;

  always_comb
  begin
    sr1_nxt = sr1_r;
    sr2_nxt = sr2_r;
    sr3_nxt = sr3_r;
    // refused writes leave every bit but the write latch as it was
    if (wrSr1 && srWriteOk)
    begin
      sr1_nxt.statusGuard = wr1.statusGuard;
      sr1_nxt.topBottomSelect = wr1.topBottomSelect;
      sr1_nxt.blockGuard = wr1.blockGuard;
    end
    if (wrSr2 && srWriteOk)
    begin
      sr2_nxt.statusLockDown = wr2.statusLockDown;
      sr2_nxt.quadAllow = wr2.quadAllow;
      sr2_nxt.securityLock = sr2_r.securityLock | wr2.securityLock;
      sr2_nxt.complementGuard = wr2.complementGuard;
    end
    // powerup width only through enabled status write
    if (wrSr3 && srWriteOk)
    begin
      sr3_nxt.powerupAddressWidth = wr3.powerupAddressWidth;
      sr3_nxt.guardSchemeSelect = wr3.guardSchemeSelect;
      sr3_nxt.driveStrength = wr3.driveStrength;
    end
    if (clrWel || softRst)
      sr1_nxt.writeAllowLatch = 1'b0;
    if (doWren)
      sr1_nxt.writeAllowLatch = 1'b1;
    if (isResume || softRst)
      sr2_nxt.pausedFlag = 1'b0;
    if (isSuspend)
      sr2_nxt.pausedFlag = 1'b1;
    if (isEnter4)
      sr3_nxt.currentAddressWidth = 1'b1;
    if (isExit4)
      sr3_nxt.currentAddressWidth = 1'b0;
    if (initPend_r || softRst)
      sr3_nxt.currentAddressWidth = sr3_r.powerupAddressWidth;
    sr1_nxt.busy = 1'b0;
    sr2_nxt.reserved10 = 1'b0;
    sr3_nxt.reserved20 = 2'h0;
    sr3_nxt.reserved23 = 1'b0;
  end

  always_comb
  begin
    lockBits_nxt = lockBits_r;
    if (lockReq && latch)
      lockBits_nxt[blkAddr] = cmd_r == fsp_pkg::OP_BLK_LOCK;
    // every block lock set on reset
    if (softRst)
      lockBits_nxt = '1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr1_r <= fsp_pkg::fsp_sr1_t'(fsp_pkg::SR1_RESET);
      sr2_r <= fsp_pkg::fsp_sr2_t'(fsp_pkg::SR2_RESET);
      sr3_r <= fsp_pkg::fsp_sr3_t'(fsp_pkg::SR3_RESET);
      lockBits_r <= '1;
      initPend_r <= 1'b1;
    end
    else
    begin
      sr1_r <= sr1_nxt;
      sr2_r <= sr2_nxt;
      sr3_r <= sr3_nxt;
      lockBits_r <= lockBits_nxt;
      initPend_r <= 1'b0;
    end
  end

  // prefix and reset sequences are consumed by the very next frame
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      otpLock_r <= 1'b0;
      armStage_r <= 2'h0;
      rstArm_r <= 1'b0;
    end
    else if (exec)
    begin
      // permanent lock only after the two prefix bytes
      if (wrSr2 && srWriteOk && armStage_r == 2'h2 && wr2.statusLockDown)
        otpLock_r <= 1'b1;
      armStage_r <= isPrefixA ? 2'h1 : isPrefixB ? 2'h2 : 2'h0;
      rstArm_r <= isRstEn;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memOpGo_r <= 1'b0;
      memOp_r <= '0;
      pubStatus_r <= {fsp_pkg::SR3_RESET, fsp_pkg::SR2_RESET, fsp_pkg::SR1_RESET};
    end
    else
    begin
      memOpGo_r <= memGoNxt;
      if (memGoNxt)
        memOp_r <= '{kind: kindNxt, addr: addr_r};
      if (csHigh)
        pubStatus_r <= {sr3_r, sr2_r, sr1_r};
    end
  end

  assign memOpGo = memOpGo_r;
  assign memOp = memOp_r;
  assign securityLocks = sr2_r.securityLock;
  assign quadAllow = sr2_r.quadAllow;
  // pause pin lives only without quad
  assign pauseEnable = !sr2_r.quadAllow;
  assign driveStrength = sr3_r.driveStrength;
  assign addr4Byte = sr3_r.currentAddressWidth;
  assign guardScheme = sr3_r.guardSchemeSelect;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_soft_write_ok: assert property (
    (wrSr1 && !sr1_r.statusGuard && latch && !sr2_r.statusLockDown && !otpLock_r)
    |=> sr1_r.blockGuard == $past(data1_r[5:2]))
    else $error("enabled status write not applied");
  a_pin_low_lock: assert property (
    (wrSr1 && sr1_r.statusGuard && !sr2_r.quadAllow && !wpSync_r[1])
    |=> $stable(sr1_r.blockGuard) && $stable(sr1_r.topBottomSelect))
    else $error("status write passed a low protect pin");
  a_lockdown_freeze: assert property (
    (sr2_r.statusLockDown && wrSr3)
    |=> $stable(sr3_r.driveStrength) && $stable(sr3_r.guardSchemeSelect))
    else $error("status write passed lock-down");
  a_paused_set: assert property (
    isSuspend |=> sr2_r.pausedFlag ##0 (!isResume && !softRst) [*1] ##1 sr2_r.pausedFlag)
    else $error("paused flag not held after suspend");
  a_seclock_sticky: assert property (
    (sr2_r.securityLock != 3'h0) |=> ((sr2_r.securityLock & $past(sr2_r.securityLock))
    == $past(sr2_r.securityLock)))
    else $error("security lock cleared");
  a_guarded_no_go: assert property (
    (memReq && blkProt) || (ceReq && anyProt) |=> !memOpGo_r)
    else $error("guarded operation issued");
  a_top_one_block: assert property (
    (!sr3_r.guardSchemeSelect && !invert && bp == 4'h1 && !sr1_r.topBottomSelect)
    |-> blkProt == (blkAddr == 9'h1FF))
    else $error("top block map wrong");
  a_full_array: assert property (
    (!sr3_r.guardSchemeSelect && !invert && bpAll) |-> blkProt && anyProt)
    else $error("full array not guarded");
  a_start_width: assert property (
    softRst |=> sr3_r.currentAddressWidth == $past(sr3_r.powerupAddressWidth))
    else $error("address mode not restored on reset");
  a_latch_cycle: assert property (
    doWren |=> latch)
    else $error("write latch not set by enable");
  a_latch_clear: assert property (
    clrWel |=> !latch)
    else $error("write latch not cleared by write command");

  c_enabled_write: cover property (doWren ##[1:400] (wrSr1 && srWriteOk));
  c_mem_go: cover property (memOpGo_r);
  c_otp_lock: cover property (wrSr2 && armStage_r == 2'h2);
  c_soft_reset: cover property (softRst);
endmodule

// ===== hw/fsp_pkg.sv
/*
  Shared constants and carrier types for the flash status and protection block.
  Assumes one clock domain for the register state and one for the serial link.
*/
package fsp_pkg;
  // instruction codes seen on the serial link
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_ENTER4 = 8'hB7;
  localparam logic [7:0] OP_EXIT4 = 8'hE9;
  localparam logic [7:0] OP_PREFIX_A = 8'hAA;
  localparam logic [7:0] OP_PREFIX_B = 8'h55;
  localparam logic [7:0] OP_RESET_EN = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
  localparam logic [7:0] OP_BLK_LOCK = 8'h36;
  localparam logic [7:0] OP_BLK_UNLOCK = 8'h39;
  // array geometry: 512 blocks of 64KB
  localparam logic [9:0] BLOCK_COUNT = 10'h200;
  localparam int BLOCK_LSB = 16;
  localparam int SEC_IDX_LSB = 12;
  localparam logic [2:0] ADDR3_BYTES = 3'h3;
  localparam logic [2:0] ADDR4_BYTES = 3'h4;
  // values after power-up
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] SR3_RESET = 8'h60;
  localparam logic [1:0] SYNC_IDLE_HIGH = 2'h3;
  // drive strength codes
  localparam logic [1:0] DRIVE_100 = 2'h0;
  localparam logic [1:0] DRIVE_75 = 2'h1;
  localparam logic [1:0] DRIVE_50 = 2'h2;
  localparam logic [1:0] DRIVE_25 = 2'h3;

  typedef struct packed {
    logic statusGuard;
    logic topBottomSelect;
    logic [3:0] blockGuard;
    logic writeAllowLatch;
    logic busy;
  } fsp_sr1_t;

  typedef struct packed {
    logic pausedFlag;
    logic complementGuard;
    logic [2:0] securityLock;
    logic reserved10;
    logic quadAllow;
    logic statusLockDown;
  } fsp_sr2_t;

  typedef struct packed {
    logic reserved23;
    logic [1:0] driveStrength;
    logic [1:0] reserved20;
    logic guardSchemeSelect;
    logic powerupAddressWidth;
    logic currentAddressWidth;
  } fsp_sr3_t;

  typedef enum logic [2:0] {
    MOP_PAGE_PROGRAM,
    MOP_SECTOR_ERASE,
    MOP_BLOCK_ERASE,
    MOP_CHIP_ERASE,
    MOP_SEC_ERASE,
    MOP_SEC_PROGRAM
  } fsp_memop_kind_t;

  typedef struct packed {
    fsp_memop_kind_t kind;
    logic [31:0] addr;
  } fsp_memop_t;
endpackage

// ===== verification/fsp_spi_host.sv
/*
  Serial link host model for the flash status block.
  Assumes mode 0 framing, 80 ns link period, clock idle low between frames.
*/
module fsp_spi_host (
  output logic spiClk, // link clock
  output logic spiCsN, // chip select
  output logic spiMosi, // data to device
  input wire logic spiMiso, // data from device
  input wire logic spiMisoOeN // device drives data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end

  // whole bytes only, msb first
  task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] rd,
                      output logic oeLow);
    int i;
    rd = 8'h00;
    oeLow = 1'b0;
    spiCsN = 1'b0;
    #120;
    for (i = 0; i < n * 8; i++)
    begin
      spiMosi = d[39 - i];
      #40;
      spiClk = 1'b1;
      if (i >= 8 && i < 16)
        rd = {rd[6:0], spiMiso};
      if (i == 8)
        oeLow = (spiMisoOeN === 1'b0);
      #40;
      spiClk = 1'b0;
    end
    #40;
    spiCsN = 1'b1;
    // released line must not keep its last value
    spiMosi = ~spiMosi;
    // gap covers execute latency and minimum deselect time
    #800;
  endtask
endmodule

// ===== verification/tb.sv
/*
  Self-checking bench for the flash status and protection block.
  Assumes the host model drives the link; rst_n stands for a power cycle.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wpPinN = 1'b1;
  logic spiClk, spiCsN, spiMosi, spiMiso, spiMisoOeN, memOpGo;
  fsp_pkg::fsp_memop_t memOp;
  logic [2:0] securityLocks;
  logic quadAllow, pauseEnable, addr4Byte, guardScheme;
  logic [1:0] driveStrength;
  logic [7:0] rdByte;
  logic oeLow;
  int failCount = 0;
  int nTests = 0;
  int goCount = 0;

  always #25 clock = ~clock;

  always @(posedge clock)
    if (memOpGo === 1'b1)
      goCount <= goCount + 1;

  fsp_core dut (.clock(clock), .rst_n(rst_n), .spiClk(spiClk), .spiCsN(spiCsN),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOeN(spiMisoOeN), .wpPinN(wpPinN),
    .memOpGo(memOpGo), .memOp(memOp), .securityLocks(securityLocks),
    .quadAllow(quadAllow), .pauseEnable(pauseEnable), .driveStrength(driveStrength),
    .addr4Byte(addr4Byte), .guardScheme(guardScheme));

  fsp_spi_host host (.spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoOeN(spiMisoOeN));

  task automatic printVerdict();
    if (failCount == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    nTests++;
    if (g !== e)
    begin
      failCount++;
      $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
    end
  endtask

  // expected guard of one block, map scheme
  function automatic logic prot(logic [3:0] bp, logic t, logic c, int b);
    int n;
    logic p;
    n = 1 << (bp - 1);
    if (bp == 4'h0)
      p = 1'b0;
    else if (bp[3] && (bp[1] || bp[2]))
      p = 1'b1;
    else
      p = t ? (b < n) : (b >= 512 - n);
    return p ^ c;
  endfunction

  task automatic xf(input logic [39:0] d, input int n);
    host.xfer(d, n, rdByte, oeLow);
  endtask

  task automatic cr(input logic [7:0] op, input logic [7:0] e);
    xf({op, 32'h0}, 2);
    chk(rdByte, e);
  endtask

  task automatic wr(input logic [7:0] op, input logic [7:0] v);
    xf({8'h06, 32'h0}, 1);
    xf({op, v, 24'h0}, 2);
  endtask

  // array operation after write enable; e pulses expected, x = {kind, addr}
  task automatic op(input logic [39:0] d, input int n, input int e, input logic [39:0] x);
    int g;
    xf({8'h06, 32'h0}, 1);
    g = goCount;
    xf(d, n);
    chk(goCount - g, e);
    if (goCount != g)
      chk({memOp.kind, memOp.addr}, x);
  endtask

  task automatic er(input logic [8:0] b, input int e);
    op({8'hD8, 7'h00, b, 16'h0000}, 5, e, {fsp_pkg::MOP_BLOCK_ERASE, 7'h00, b, 16'h0000});
  endtask

  task automatic pwr();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  task automatic pin(input logic v);
    @(posedge clock);
    wpPinN <= v;
  endtask

  initial
  begin
    #4000000;
    failCount++;
    printVerdict();
  end

  initial
  begin
    int k;
    logic [3:0] bp;
    logic t, c;
    logic [8:0] blk;
    void'($urandom(95));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    cr(8'h05, 8'h00);
    chk(oeLow, 1'b1);
    cr(8'h35, 8'h00);
    cr(8'h15, 8'h60);
    chk({driveStrength, pauseEnable, addr4Byte, guardScheme}, 5'h1C);
    xf({8'h01, 8'hFC, 24'h0}, 2);
    cr(8'h05, 8'h00);
    xf({8'h06, 32'h0}, 1);
    cr(8'h05, 8'h02);
    xf({8'h04, 32'h0}, 1);
    cr(8'h05, 8'h00);
    pin(1'b0);
    wr(8'h01, 8'h3C);
    cr(8'h05, 8'h3C);
    wr(8'h01, 8'h80);
    wr(8'h01, 8'h00);
    cr(8'h05, 8'h80);
    pin(1'b1);
    wr(8'h01, 8'h84);
    cr(8'h05, 8'h84);
    wr(8'h31, 8'h02);
    chk({quadAllow, pauseEnable}, 2'h2);
    pin(1'b0);
    wr(8'h01, 8'h80);
    cr(8'h05, 8'h80);
    wr(8'h31, 8'h00);
    chk({quadAllow, pauseEnable}, 2'h1);
    pin(1'b1);
    wr(8'h01, 8'h00);
    xf({8'h75, 32'h0}, 1);
    cr(8'h35, 8'h80);
    xf({8'h7A, 32'h0}, 1);
    cr(8'h35, 8'h00);
    wr(8'h31, 8'h08);
    chk(securityLocks, 3'h1);
    wr(8'h31, 8'h20);
    wr(8'h31, 8'h00);
    cr(8'h35, 8'h28);
    chk(securityLocks, 3'h5);
    for (k = 0; k < 4; k++)
    begin
      wr(8'h11, {1'b0, k[1:0], 5'h00});
      chk(driveStrength, k[1:0]);
    end
    xf({8'hB7, 32'h0}, 1);
    cr(8'h15, 8'h61);
    xf({8'hE9, 32'h0}, 1);
    // powerup width via write enable then write status three
    wr(8'h11, 8'h62);
    cr(8'h15, 8'h62);
    xf({8'h66, 32'h0}, 1);
    xf({8'h99, 32'h0}, 1);
    chk(addr4Byte, 1'b1);
    for (k = 0; k < 48; k++)
    begin
      bp = (k < 16) ? k[3:0] : 4'($urandom_range(15, 0));
      // first two passes pinned to top, no complement, so the one-block map is hit
      t = (k < 2) ? 1'b0 : 1'($urandom_range(1, 0));
      c = (k < 2) ? 1'b0 : 1'($urandom_range(1, 0));
      blk = (k % 3 == 0) ? 9'($urandom_range(511, 0)) :
            (k % 3 == 1) ? 9'($urandom_range(7, 0)) : 9'(511 - $urandom_range(7, 0));
      wr(8'h01, {1'b0, t, bp, 2'h0});
      wr(8'h31, {1'b0, c, 6'h00});
      er(blk, !prot(bp, t, c, blk));
    end
    wr(8'h01, 8'h00);
    wr(8'h31, 8'h00);
    op({8'hC7, 32'h0}, 1, 1, {fsp_pkg::MOP_CHIP_ERASE, 32'h0});
    op({8'h02, 32'h01FF_0000}, 5, 1, {fsp_pkg::MOP_PAGE_PROGRAM, 32'h01FF_0000});
    op({8'h20, 32'h0000_3000}, 5, 1, {fsp_pkg::MOP_SECTOR_ERASE, 32'h0000_3000});
    op({8'h42, 32'h0000_1000}, 5, 0, 40'h00_0000_0000);
    op({8'h44, 32'h0000_2000}, 5, 1, {fsp_pkg::MOP_SEC_ERASE, 32'h0000_2000});
    wr(8'h11, 8'h66);
    wr(8'h01, 8'h00);
    wr(8'h31, 8'h00);
    chk(guardScheme, 1'b1);
    er(9'h005, 0);
    xf({8'h06, 32'h0}, 1);
    xf({8'h39, 7'h00, 9'h005, 16'h0000}, 5);
    er(9'h005, 1);
    xf({8'h66, 32'h0}, 1);
    xf({8'h99, 32'h0}, 1);
    er(9'h005, 0);
    wr(8'h31, 8'h01);
    wr(8'h01, 8'h3C);
    cr(8'h05, 8'h00);
    wr(8'h11, 8'h00);
    cr(8'h15, 8'h67);
    pwr();
    cr(8'h35, 8'h00);
    wr(8'h01, 8'h04);
    cr(8'h05, 8'h04);
    // prefix pair then the locking status write
    xf({8'h06, 32'h0}, 1);
    xf({8'hAA, 32'h0}, 1);
    xf({8'h55, 32'h0}, 1);
    xf({8'h31, 8'h01, 24'h0}, 2);
    wr(8'h31, 8'h00);
    wr(8'h01, 8'h00);
    cr(8'h35, 8'h01);
    cr(8'h05, 8'h04);
    printVerdict();
  end
endmodule
